/* verilog/logic_cluster.sv */
// Behaviour
// - each table: four inputs, any function
// - slice: two tables, elements, combiners, carry
// - storage element: flip-flop or latch
// - every table loadable as read-only memory
// - memory and shift only in left pair
// - left table holds sixteen RAM bits
// - dual port pairs two tables
// - shift delay one to sixteen edges
// - four left tables chain to 64
// - chain continues across clusters
// - carry in, out, five steering muxes
// - sum and product gate per half
// - lower and upper wide combiners
// - four slices, two independent carry columns
//
// The address map and register access over APB were decided locally.
`default_nettype none
module logic_cluster
  import cluster_pkg::*;
(
  // clock and reset
  input  wire logic        CLK_SYS,
  input  wire logic        RST_N,
  // apb slave
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [7:0]  PADDR,
  input  wire logic [31:0] PWDATA,
  output logic [31:0]      PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  // routing inputs
  input  wire logic        USER_CLK,
  input  wire logic [31:0] LUT_IN,
  input  wire logic [3:0]  BX,
  input  wire logic [3:0]  BY,
  input  wire logic [1:0]  WR_EN,
  input  wire logic [3:0]  WR_DATA,
  input  wire logic [1:0]  CARRY_IN,
  input  wire logic        CHAIN_IN,
  input  wire logic        WIDE_IN,
  // routing outputs
  output logic [7:0]       LUT_OUT,
  output logic [7:0]       SUM_OUT,
  output logic [7:0]       Q_OUT,
  output logic [1:0]       CARRY_OUT,
  output logic             CHAIN_OUT,
  output logic             WIDE_OUT
);
  logic [31:0] mode_q;
  logic [31:0] carry_q;
  logic        uclk_s1_q;
  logic        uclk_s2_q;
  logic        uclk_s3_q;
  logic        uclk_q;
  logic        uclk_rise;
  logic        apb_acc;
  logic        apb_wr;
  logic        hit;
  logic [31:0] rd_val;
  logic [15:0] cont [NUM_LUT];
  logic [7:0]  lut_d;
  logic [7:0]  sum;
  logic [7:0]  st_d;
  logic [3:0]  co;
  logic [3:0]  co_f;
  logic [3:0]  f5;
  logic [3:0]  fi;
  logic [3:0]  ci_init;

  function automatic logic [7:0] slice_cfg(input logic [31:0] r, input int s);
    slice_cfg = r[s*CARRY_FIELD_W +: CARRY_FIELD_W];
  endfunction : slice_cfg

  // user clock pin: three stages, change accepted when stages two and three agree
  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      uclk_s1_q <= 1'b0;
      uclk_s2_q <= 1'b0;
      uclk_s3_q <= 1'b0;
    end else begin
      uclk_s1_q <= USER_CLK;
      uclk_s2_q <= uclk_s1_q;
      uclk_s3_q <= uclk_s2_q;
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      uclk_q <= 1'b0;
    end else if (uclk_s2_q == uclk_s3_q) begin
      uclk_q <= uclk_s3_q;
    end
  end

  assign uclk_rise = (uclk_s2_q == uclk_s3_q) && uclk_s3_q && !uclk_q;

  // apb: one wait state, answer registered
  assign apb_acc = PSEL && PENABLE && !PREADY;
  assign apb_wr  = PSEL && PENABLE && PREADY && PWRITE;

  always_comb begin
    hit    = 1'b1;
    rd_val = 32'h0000_0000;
    unique case (PADDR)
      OFF_MODE:   rd_val = mode_q;
      OFF_CARRY:  rd_val = carry_q;
      OFF_STATUS: rd_val = {14'h0000, co[3], co[1], Q_OUT, lut_d};
      default: begin
        hit = 1'b0;
        for (int i = 0; i < NUM_LUT; i++) begin
          if (PADDR == OFF_LUT_BASE + 8'(4 * i)) begin
            hit    = 1'b1;
            rd_val = {16'h0000, cont[i]};
          end
        end
      end
    endcase
  end

  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      PREADY  <= 1'b0;
      PRDATA  <= 32'h0000_0000;
      PSLVERR <= 1'b0;
    end else begin
      PREADY <= apb_acc;
      if (apb_acc) begin
        PRDATA  <= PWRITE ? 32'h0000_0000 : rd_val;
        PSLVERR <= !hit;
      end
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      mode_q <= MODE_RST;
    end else if (apb_wr && PADDR == OFF_MODE) begin
      mode_q <= PWDATA;
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      carry_q <= CARRY_RST;
    end else if (apb_wr && PADDR == OFF_CARRY) begin
      carry_q <= PWDATA;
    end
  end

  // tables: 2s lower, 2s+1 upper of slice s; slices 0,1 form the left pair
  for (genvar i = 0; i < NUM_LUT; i++) begin : g_lut
    localparam int S = i / 2;
    logic       sin;
    logic       we;
    logic [3:0] wa;
    logic       wb;
    logic       dual;
    if (i == 0) begin : g_head
      assign sin = CHAIN_IN;
    end else begin : g_link
      assign sin = cont[i-1][LUT_BITS-1];
    end
    if (i < NUM_MEM_LUT) begin : g_wr
      assign dual = mode_q[MODE_DUAL_POS + S] && (i % 2 == 1);
      assign we   = WR_EN[S];
      // dual port: upper table written at the lower table's address and data
      assign wa   = dual ? LUT_IN[8*S +: 4] : LUT_IN[4*i +: 4];
      assign wb   = dual ? WR_DATA[2*S] : WR_DATA[i];
    end else begin : g_nowr
      assign dual = 1'b0;
      assign we   = 1'b0;
      assign wa   = 4'h0;
      assign wb   = 1'b0;
    end
    lut_cell #(
      .MEM_OK (i < NUM_MEM_LUT)
    ) u_lut (
      .clk      (CLK_SYS),
      .rst_n    (RST_N),
      .cfg_we   (apb_wr && PADDR == OFF_LUT_BASE + 8'(4 * i)),
      .cfg_data (PWDATA[15:0]),
      .mode     (decode_mode(mode_q[MODE_FIELD_W*i +: MODE_FIELD_W])),
      .edge_i   (uclk_rise),
      .wr_en    (we),
      .wr_addr  (wa),
      .wr_bit   (wb),
      .shift_in (sin),
      .rd_addr  (LUT_IN[4*i +: 4]),
      .d        (lut_d[i]),
      .contents (cont[i])
    );
  end

  assign CHAIN_OUT = cont[NUM_MEM_LUT-1][LUT_BITS-1];

  // carry chain, arithmetic gates; each column has its own carry input
  always_comb begin
    logic [7:0] c;
    logic       carry_in_line;
    logic       gen;
    c   = 8'h00;
    carry_in_line = 1'b0;
    gen = 1'b0;
    for (int s = 0; s < NUM_SLICE; s++) begin
      c   = slice_cfg(carry_q, s);
      carry_in_line = (s % 2 == 0) ? CARRY_IN[s/2] : co[s-1];
      unique case (c[CFG_INIT_POS +: 2])
        CY_FROM_CHAIN: ci_init[s] = carry_in_line;
        CY_ZERO:       ci_init[s] = 1'b0;
        CY_ONE:        ci_init[s] = 1'b1;
        CY_FROM_BX:    ci_init[s] = BX[s];
      endcase
      gen       = c[CFG_LSRC_POS] ? BX[s] : (LUT_IN[8*s] & LUT_IN[8*s+1]);
      co_f[s]   = lut_d[2*s] ? ci_init[s] : gen;
      sum[2*s]  = lut_d[2*s] ^ ci_init[s];
      gen       = c[CFG_USRC_POS] ? BY[s] : (LUT_IN[8*s+4] & LUT_IN[8*s+5]);
      co[s]     = lut_d[2*s+1] ? co_f[s] : gen;
      sum[2*s+1] = lut_d[2*s+1] ^ co_f[s];
      f5[s]     = BX[s] ? lut_d[2*s] : lut_d[2*s+1];
    end
  end

  // upper combiners: six-input in slices 0 and 2, seven-input in slice 1, eight-input in slice 3
  always_comb begin
    fi[0] = BY[0] ? f5[1] : f5[0];
    fi[2] = BY[2] ? f5[3] : f5[2];
    fi[1] = BY[1] ? fi[2] : fi[0];
    fi[3] = BY[3] ? WIDE_IN : fi[1];
    for (int s = 0; s < NUM_SLICE; s++) begin
      st_d[2*s]   = slice_cfg(carry_q, s)[CFG_LSUM_POS] ? sum[2*s] : f5[s];
      st_d[2*s+1] = slice_cfg(carry_q, s)[CFG_USUM_POS] ? sum[2*s+1] : fi[s];
    end
  end

  for (genvar e = 0; e < NUM_LUT; e++) begin : g_store
    storage_element u_store (
      .clk        (CLK_SYS),
      .rst_n      (RST_N),
      .latch_mode (mode_q[MODE_LATCH_POS + e]),
      .uclk_high  (uclk_q),
      .uclk_rise  (uclk_rise),
      .d          (st_d[e]),
      .q          (Q_OUT[e])
    );
  end

  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      LUT_OUT   <= 8'h00;
      SUM_OUT   <= 8'h00;
      CARRY_OUT <= 2'h0;
      WIDE_OUT  <= 1'b0;
    end else begin
      LUT_OUT   <= lut_d;
      SUM_OUT   <= sum;
      CARRY_OUT <= {co[3], co[1]};
      WIDE_OUT  <= fi[3];
    end
  end

  // checks
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!RST_N);

  logic cfg_any;
  assign cfg_any = apb_wr;

  sequence s_edge_mode(int i, lut_mode_t m);
    uclk_rise && !cfg_any && decode_mode(mode_q[2*i +: 2]) == m;
  endsequence

  AST_LUT_READ: assert property (
    !cfg_any && !uclk_rise |=> LUT_OUT[7] == lut_read($past(cont[7]), $past(LUT_IN[31:28])))
    else $error("table output does not follow its contents");

  AST_RIGHT_ROM: assert property (
    !cfg_any |=> $stable(cont[4]) && $stable(cont[7]))
    else $error("logic-only table changed without a load");

  AST_RAM_WRITE: assert property (
    s_edge_mode(0, LUT_RAM) && WR_EN[0]
      |=> cont[0][$past(LUT_IN[3:0])] == $past(WR_DATA[0]))
    else $error("distributed memory write lost");

  AST_DUAL_PORT: assert property (
    s_edge_mode(1, LUT_RAM) && mode_q[MODE_DUAL_POS] && WR_EN[0]
      |=> cont[1][$past(LUT_IN[3:0])] == $past(WR_DATA[0]))
    else $error("dual-port partner not written");

  AST_SHIFT: assert property (
    s_edge_mode(0, LUT_SHIFT)
      |=> cont[0] == {$past(cont[0][14:0]), $past(CHAIN_IN)})
    else $error("shift step wrong");

  AST_CHAIN: assert property (
    s_edge_mode(3, LUT_SHIFT) |=> cont[3][0] == $past(cont[2][15]))
    else $error("cascade link broken");

  AST_CARRY_PASS: assert property (
    carry_q[1:0] == CY_FROM_CHAIN && carry_q[9:8] == CY_FROM_CHAIN
      && (&lut_d[3:0]) |=> CARRY_OUT[0] == $past(CARRY_IN[0]))
    else $error("carry not propagated through column");

  AST_COLUMNS: assert property (
    $stable(CARRY_IN[1]) && $stable(carry_q) && $stable(lut_d[7:4])
      && $stable(BX[3:2]) && $stable(BY[3:2]) && $stable(LUT_IN[31:16])
      |-> $stable(co[3]))
    else $error("right carry column depends on left");

  AST_FLOP_HOLD: assert property (
    !mode_q[MODE_LATCH_POS] && !uclk_rise |=> $stable(Q_OUT[0]))
    else $error("flip-flop changed without a clock edge");

  AST_LATCH_OPEN: assert property (
    mode_q[MODE_LATCH_POS + 1] && uclk_q |=> Q_OUT[1] == $past(st_d[1]))
    else $error("open latch does not follow data");

  AST_ROM_LOAD: assert property (
    apb_wr && PADDR == OFF_LUT_BASE |=> cont[0] == $past(PWDATA[15:0]))
    else $error("table load did not take the written contents");

  AST_SUM_ZERO: assert property (
    carry_q[CFG_INIT_POS +: 2] == CY_ZERO |=> SUM_OUT[0] == $past(lut_d[0]))
    else $error("sum gate wrong with zero carry");

  AST_WIDE_TOP: assert property (
    BY[3] |=> WIDE_OUT == $past(WIDE_IN))
    else $error("top combiner does not pass neighbour input");

  AST_RIGHT_CARRY: assert property (
    carry_q[17:16] == CY_ONE && carry_q[25:24] == CY_FROM_CHAIN
      && (&lut_d[7:4]) |=> CARRY_OUT[1])
    else $error("right column carry not propagated");

  AST_PREADY_PULSE: assert property (
    PREADY |=> !PREADY)
    else $error("ready held longer than one cycle");

  AST_APB_WAIT: assert property (
    PSEL && PENABLE && !PREADY |=> PREADY)
    else $error("access not answered after one wait state");
endmodule : logic_cluster
`default_nettype wire

/* verilog/cluster_pkg.sv */
`default_nettype none
package cluster_pkg;
  localparam int NUM_SLICE   = 4;
  localparam int NUM_LUT     = 8;
  localparam int NUM_MEM_LUT = 4;
  localparam int LUT_BITS    = 16;
  localparam int LUT_AW      = 4;

  localparam logic [7:0] OFF_MODE     = 8'h00;
  localparam logic [7:0] OFF_CARRY    = 8'h04;
  localparam logic [7:0] OFF_STATUS   = 8'h08;
  localparam logic [7:0] OFF_LUT_BASE = 8'h20;

  // mode register: 2 bits per table, dual-port bit per memory slice, latch bit per element
  localparam int MODE_FIELD_W   = 2;
  localparam int MODE_DUAL_POS  = 16;
  localparam int MODE_LATCH_POS = 18;
  // carry register: one byte per slice
  localparam int CARRY_FIELD_W  = 8;
  localparam int CFG_INIT_POS   = 0;
  localparam int CFG_LSRC_POS   = 2;
  localparam int CFG_USRC_POS   = 3;
  localparam int CFG_LSUM_POS   = 4;
  localparam int CFG_USUM_POS   = 5;

  localparam logic [31:0] MODE_RST  = 32'h0000_0000;
  localparam logic [31:0] CARRY_RST = 32'h0000_0000;
  localparam logic [15:0] LUT_RST   = 16'h0000;

  localparam logic [1:0] CY_FROM_CHAIN = 2'h0;
  localparam logic [1:0] CY_ZERO       = 2'h1;
  localparam logic [1:0] CY_ONE        = 2'h2;
  localparam logic [1:0] CY_FROM_BX    = 2'h3;

  typedef enum logic [2:0] {
    LUT_LOGIC = 3'b001,
    LUT_RAM   = 3'b010,
    LUT_SHIFT = 3'b100
  } lut_mode_t;

  function automatic lut_mode_t decode_mode(input logic [1:0] f);
    unique case (f)
      2'h1:    decode_mode = LUT_RAM;
      2'h2:    decode_mode = LUT_SHIFT;
      default: decode_mode = LUT_LOGIC;
    endcase
  endfunction : decode_mode

  function automatic logic lut_read(input logic [15:0] c, input logic [3:0] a);
    lut_read = c[a];
  endfunction : lut_read
endpackage : cluster_pkg
`default_nettype wire

/* verilog/lut_cell.sv */
`default_nettype none
module lut_cell
  import cluster_pkg::*;
#(
  parameter bit MEM_OK = 1'b1
) (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // configuration load
  input  wire logic        cfg_we,
  input  wire logic [15:0] cfg_data,
  input  wire lut_mode_t   mode,
  // user-clock event and write / shift data
  input  wire logic        edge_i,
  input  wire logic        wr_en,
  input  wire logic [3:0]  wr_addr,
  input  wire logic        wr_bit,
  input  wire logic        shift_in,
  // lookup
  input  wire logic [3:0]  rd_addr,
  output logic             d,
  output logic [15:0]      contents
);
  lut_mode_t   mode_eff;
  logic [15:0] cont_q;

  // logic-only tables ignore memory and shift modes
  assign mode_eff = MEM_OK ? mode : LUT_LOGIC;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cont_q <= LUT_RST;
    end else if (cfg_we) begin
      cont_q <= cfg_data;
    end else if (edge_i) begin
      unique case (mode_eff)
        LUT_RAM: begin
          if (wr_en) begin
            cont_q[wr_addr] <= wr_bit;
          end
        end
        LUT_SHIFT: begin
          cont_q <= {cont_q[14:0], shift_in};
        end
        LUT_LOGIC: begin
          cont_q <= cont_q;
        end
      endcase
    end
  end

  assign d        = lut_read(cont_q, rd_addr);
  assign contents = cont_q;
endmodule : lut_cell
`default_nettype wire

/* verilog/storage_element.sv */
`default_nettype none
module storage_element (
  // clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // mode and user clock state
  input  wire logic latch_mode,
  input  wire logic uclk_high,
  input  wire logic uclk_rise,
  // data
  input  wire logic d,
  output logic      q
);
  logic q_d;

  always_comb begin
    if (latch_mode) begin
      q_d = uclk_high ? d : q;
    end else begin
      q_d = uclk_rise ? d : q;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      q <= 1'b0;
    end else begin
      q <= q_d;
    end
  end
endmodule : storage_element
`default_nettype wire

/* tb/fabric_drive.sv */
`default_nettype none
// far-side routing: makes one user clock period per request
module fabric_drive (
  // clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // request and user clock
  input  wire logic req,
  output logic      user_clk,
  output logic      busy
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] cnt_q;
  // high for 8 cycles then low; well above the three-stage sync minimum
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cnt_q <= 4'h0;
    end else if (req && cnt_q == 4'h0) begin
      cnt_q <= 4'hF;
    end else if (cnt_q != 4'h0) begin
      cnt_q <= cnt_q - 4'h1;
    end
  end
  assign user_clk = cnt_q[3];
  assign busy     = (cnt_q != 4'h0);
endmodule : fabric_drive
`default_nettype wire

/* tb/tb_configurable_logic_slice.sv */
`default_nettype none
module tb_configurable_logic_slice
  import cluster_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic [2:0]  t;
    logic [15:0] c;
    logic [3:0]  a;
    logic        e;
  } row_t;
  // table, contents, table inputs, expected table output
  localparam row_t ROWS [8] = '{
    '{3'h0, 16'hA5C3, 4'h0, 1'h1}, '{3'h1, 16'h8000, 4'hF, 1'h1},
    '{3'h2, 16'h7FFF, 4'hF, 1'h0}, '{3'h3, 16'h0010, 4'h4, 1'h1},
    '{3'h4, 16'hFFEF, 4'h4, 1'h0}, '{3'h5, 16'h6996, 4'h3, 1'h0},
    '{3'h6, 16'h6996, 4'h1, 1'h1}, '{3'h7, 16'h0001, 4'h1, 1'h0}};
  logic        clk_sys = 1'b0;
  logic        rst_n, psel, penable, pwrite, chain_in, req;
  logic [7:0]  paddr;
  logic [31:0] pwdata, lut_in, rdata;
  logic [1:0]  wr_en;
  logic [3:0]  wr_data;
  logic        rerr, wide_in;
  logic [3:0]  bx, by;
  logic [1:0]  carry_in;
  wire  [31:0] prdata;
  wire         pready, pslverr, chain_out, user_clk, busy, wide_out;
  wire  [7:0]  lut_out, sum_out, q_out;
  wire  [1:0]  carry_out;
  int          n_errors  = 0;
  int          cmp_count = 0;

  always #2 clk_sys = ~clk_sys;

  logic_cluster i_logic_cluster (
    .CLK_SYS(clk_sys), .RST_N(rst_n), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
    .PREADY(pready), .PSLVERR(pslverr), .USER_CLK(user_clk), .LUT_IN(lut_in),
    .BX(bx), .BY(by), .WR_EN(wr_en), .WR_DATA(wr_data), .CARRY_IN(carry_in),
    .CHAIN_IN(chain_in), .WIDE_IN(wide_in), .LUT_OUT(lut_out), .SUM_OUT(sum_out),
    .Q_OUT(q_out), .CARRY_OUT(carry_out), .CHAIN_OUT(chain_out), .WIDE_OUT(wide_out));

  fabric_drive i_fabric_drive (
    .clk(clk_sys), .rst_n(rst_n), .req(req), .user_clk(user_clk), .busy(busy));

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // one apb transfer; holds the request until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk_sys);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      n_errors++;
    end
    rdata = prdata;
    rerr  = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic pulse();
    int n;
    @(posedge clk_sys);
    req <= 1'b1;
    @(posedge clk_sys);
    req <= 1'b0;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (busy !== 1'b0 && n < 40);
    if (busy !== 1'b0) begin
      n_errors++;
    end
    repeat (2) @(posedge clk_sys);
  endtask : pulse

  task automatic report_and_stop();
    $display("errors %0d comparisons %0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : report_and_stop

  initial begin
    repeat (20000) @(posedge clk_sys);
    n_errors++;
    report_and_stop();
  end

  initial begin
    logic [7:0] a;
    rst_n = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00;
    pwdata = 32'h0; lut_in = 32'h0; wr_en = 2'h0; wr_data = 4'h0;
    chain_in = 1'b0; req = 1'b0; bx = 4'h0; by = 4'h0; carry_in = 2'h0; wide_in = 1'b0;
    repeat (20) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(posedge clk_sys);
    chk(lut_out, 32'h0);
    apb(1'b0, OFF_MODE, 32'h0);
    chk(rdata, MODE_RST);
    apb(1'b0, OFF_CARRY, 32'h0);
    chk(rdata, CARRY_RST);
    for (int i = 0; i < 8; i++) begin
      a = OFF_LUT_BASE + 8'(4 * ROWS[i].t);
      apb(1'b1, a, {16'h0, ROWS[i].c});
      lut_in[4 * ROWS[i].t +: 4] <= ROWS[i].a;
      repeat (3) @(posedge clk_sys);
      chk(lut_out[ROWS[i].t], ROWS[i].e);
      apb(1'b0, a, 32'h0);
      chk(rdata, {16'h0, ROWS[i].c});
    end
    chk(lut_out, 32'h4B);
    chk(chain_out, 32'h0);
    // status is read-only: a write must not disturb it
    apb(1'b1, OFF_STATUS, 32'hFFFF_FFFF);
    apb(1'b0, OFF_STATUS, 32'h0);
    chk(rdata[7:0], 32'h4B);
    apb(1'b1, 8'h10, 32'h1234_5678);
    chk(rerr, 32'h1);
    apb(1'b0, 8'h10, 32'h0);
    chk(rerr, 32'h1);
    chk(rdata, 32'h0);
    apb(1'b1, OFF_LUT_BASE + 8'h0C, 32'h8000);
    repeat (3) @(posedge clk_sys);
    chk(chain_out, 32'h1);
    // table 0 shift, table 1 ram, table 3 shift, table 4 shift (refused on the right pair)
    apb(1'b1, OFF_MODE, 32'h0286);
    apb(1'b0, OFF_MODE, 32'h0);
    chk(rdata, 32'h0286);
    lut_in[7:4] <= 4'h9;
    chain_in    <= 1'b1;
    wr_en       <= 2'h1;
    wr_data     <= 4'h2;
    pulse();
    chain_in <= 1'b0;
    pulse();
    wr_en <= 2'h0;
    chk(chain_out, 32'h0);
    apb(1'b0, OFF_LUT_BASE, 32'h0);
    chk(rdata, 32'h970E);
    apb(1'b0, OFF_LUT_BASE + 8'h04, 32'h0);
    chk(rdata, 32'h8200);
    apb(1'b0, OFF_LUT_BASE + 8'h10, 32'h0);
    chk(rdata, 32'hFFEF);
    repeat (3) @(posedge clk_sys);
    chk(lut_out[0], 32'h0);
    lut_in[3:0] <= 4'h1;
    repeat (3) @(posedge clk_sys);
    chk(lut_out[0], 32'h1);
    // dual port: table 1 written at table 0's address and data
    apb(1'b1, OFF_MODE, 32'h0001_0005);
    lut_in[3:0] <= 4'h0;
    wr_en       <= 2'h1;
    wr_data     <= 4'h1;
    pulse();
    wr_en <= 2'h0;
    apb(1'b0, OFF_LUT_BASE, 32'h0);
    chk(rdata, 32'h970F);
    apb(1'b0, OFF_LUT_BASE + 8'h04, 32'h0);
    chk(rdata, 32'h8201);
    // carry columns: left tables propagate, right tables generate; element 1 latches
    apb(1'b1, OFF_MODE, 32'h0008_0000);
    for (int i = 0; i < 8; i++) begin
      apb(1'b1, OFF_LUT_BASE + 8'(4 * i), (i < 4) ? 32'hFFFF : 32'h0);
    end
    lut_in   <= 32'h0;
    carry_in <= 2'h1;
    repeat (3) @(posedge clk_sys);
    chk(carry_out, 32'h1);
    chk(sum_out, 32'h00);
    carry_in <= 2'h0;
    repeat (3) @(posedge clk_sys);
    chk(carry_out, 32'h0);
    chk(sum_out, 32'h0F);
    carry_in <= 2'h3;
    repeat (3) @(posedge clk_sys);
    chk(carry_out, 32'h1);
    chk(sum_out, 32'h10);
    chk(wide_out, 32'h1);
    pulse();
    chk(q_out, 32'h8F);
    by <= 4'h8;
    repeat (3) @(posedge clk_sys);
    chk(wide_out, 32'h0);
    wide_in <= 1'b1;
    repeat (3) @(posedge clk_sys);
    chk(wide_out, 32'h1);
    report_and_stop();
  end
endmodule : tb_configurable_logic_slice
`default_nettype wire
